//--- verilog/mbs_regs.vh
// constants for the muting and bypass state control
`ifndef MBS_REGS_VH
`define MBS_REGS_VH

// clock rate and derived cycle counts
`define MBS_CLK_HZ          10000000
`define MBS_BLINK_HALF_MS   500
`define MBS_BLINK_HALF_CYC  (`MBS_CLK_HZ / 1000 * `MBS_BLINK_HALF_MS)
`define MBS_DEBOUNCE_MS     10
`define MBS_DEBOUNCE_CYC    (`MBS_CLK_HZ / 1000 * `MBS_DEBOUNCE_MS)
`define MBS_MUTE_LIMIT_S    600
// half-second ticks in the bypass mute limit
`define MBS_MUTE_LIMIT_TICKS 12'd1200

// state codes
`define MBS_ST_INTERLOCK    3'h0
`define MBS_ST_RUN          3'h1
`define MBS_ST_STOP         3'h2
`define MBS_ST_BYPASS       3'h3
`define MBS_ST_MUTE         3'h4

// two-digit diagnostic codes, one BCD digit per nibble
`define MBS_DIAG_RUN        8'h00
`define MBS_DIAG_HALT       8'h01
`define MBS_DIAG_MUTE       8'h02
`define MBS_DIAG_BYPASS     8'h03

// sensor positions
`define MBS_SNS_A           0
`define MBS_SNS_B           1

`endif

//--- verilog/mbs_start_filter.v
// start button filter: one pulse per debounced press and release
`timescale 1ns/1ps
`default_nettype none
module mbs_start_filter #(
  parameter integer DEBOUNCE_CYC = 100000
) (
  input  wire i_clk,
  input  wire i_rst,
  input  wire i_button,
  output reg  o_release
);

  reg        stable_reg;
  reg [16:0] cnt_reg;

  // level must hold a full debounce interval before it is accepted
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      stable_reg <= 1'b0;
      cnt_reg    <= 17'h0;
      o_release  <= 1'b0;
    end else begin
      o_release <= 1'b0;
      if (i_button == stable_reg) begin
        cnt_reg <= 17'h0;
      end else if (cnt_reg >= DEBOUNCE_CYC[16:0] - 17'h1) begin
        cnt_reg    <= 17'h0;
        stable_reg <= i_button;
        // command only on the falling edge of a stable press
        o_release  <= stable_reg;
      end else begin
        cnt_reg <= cnt_reg + 17'h1;
      end
    end
  end

endmodule // mbs_start_filter
`default_nettype wire

//--- verilog/mbs_state_ctrl.v
// muting and bypass state control of a safety muting module
// Behaviour
// - power-up enters interlock, outputs off, notes sensors already active
// - interlock, curtain clear, start press-release: run with outputs on
// - run with unreleased power-up sensor and curtain blocked: stop/bypass
// - bypass-allowed blinks muting lamp and shows code 03
// - bypass start press-release enters muting, outputs on, lamp on, 02
// - curtain clears while muting after bypass: run, lamp off, code 00
// - all sensors clear in run: stay in run and re-arm auto muting
// - bypass needs both config switches, mute enable, curtain off, sensor
// - auxiliary output toggles near 1 Hz in bypass, steady on in muting
// - bypass muting limited to 10 minutes, then back to bypass-allowed
// - sensors all clear before curtain while bypass muting: machine stop
`timescale 1ns/1ps
`default_nettype none
`include "mbs_regs.vh"
module mbs_state_ctrl #(
  parameter integer BLINK_HALF_CYC = `MBS_BLINK_HALF_CYC,
  parameter integer DEBOUNCE_CYC   = `MBS_DEBOUNCE_CYC
) (
  input  wire       I_CLK_SYS,
  input  wire       I_SYS_RST,
  input  wire       i_curtain_a,
  input  wire       i_curtain_b,
  input  wire [3:0] i_mute_sensor,
  input  wire       i_mute_enable,
  input  wire [1:0] i_bypass_cfg,
  input  wire       i_start,
  output reg        o_safety_switching_output_a,
  output reg        o_safety_switching_output_b,
  output reg        o_mute_lamp,
  output reg        o_mute_aux,
  output reg  [7:0] o_diag_code,
  output reg  [2:0] o_state
);

  reg  [2:0]  state_reg;
  reg  [2:0]  state_next;
  reg         armed_reg;
  reg         armed_next;
  reg         via_bypass_reg;
  reg         via_bypass_next;
  reg         boot_reg;
  reg  [22:0] half_cnt_reg;
  reg         blink_reg;
  reg  [11:0] mute_ticks_reg;
  wire        start_cmd;
  wire        curtain_clear;
  wire        any_sensor;
  wire        bypass_ok;
  wire        auto_mute_ok;
  wire        half_tick;
  wire        mute_timeout;

  // start button filtering
  // release after press
  mbs_start_filter #(
    .DEBOUNCE_CYC (DEBOUNCE_CYC)
  ) u_start (
    .i_clk     (I_CLK_SYS),
    .i_rst     (I_SYS_RST),
    .i_button  (i_start),
    .o_release (start_cmd)
  );

  // curtain clear only when both of its outputs are on
  assign curtain_clear = i_curtain_a & i_curtain_b;
  assign any_sensor    = |i_mute_sensor;
  assign bypass_ok     = (&i_bypass_cfg) & i_mute_enable &
                         ~curtain_clear & any_sensor;
  // armed muting needs the leading sensor pair active together
  assign auto_mute_ok  = armed_reg & i_mute_enable &
                         i_mute_sensor[`MBS_SNS_A] &
                         i_mute_sensor[`MBS_SNS_B];

  // free-running half-second time base
  assign half_tick = (half_cnt_reg == BLINK_HALF_CYC[22:0] - 23'h1);
  always @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      half_cnt_reg <= 23'h0;
      blink_reg    <= 1'b0;
    end else if (half_tick) begin
      half_cnt_reg <= 23'h0;
      blink_reg    <= ~blink_reg;
    end else begin
      half_cnt_reg <= half_cnt_reg + 23'h1;
    end
  end

  // uninterrupted bypass muting time in half seconds
  // ten minute limit
  assign mute_timeout = (mute_ticks_reg >= `MBS_MUTE_LIMIT_TICKS);
  always @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      mute_ticks_reg <= 12'h0;
    end else if (state_reg != `MBS_ST_MUTE || !via_bypass_reg) begin
      mute_ticks_reg <= 12'h0;
    end else if (half_tick && !mute_timeout) begin
      mute_ticks_reg <= mute_ticks_reg + 12'h1;
    end
  end

  // next-state logic
  always @* begin
    state_next      = state_reg;
    armed_next      = armed_reg;
    via_bypass_next = via_bypass_reg;
    if (boot_reg && any_sensor) begin
      armed_next = 1'b0;
    end else if (!any_sensor) begin
      armed_next = 1'b1;
    end
    case (state_reg)
      `MBS_ST_INTERLOCK: begin
        if (start_cmd && curtain_clear) begin
          state_next = `MBS_ST_RUN;
        end
      end
      `MBS_ST_RUN: begin
        if (!curtain_clear) begin
          if (auto_mute_ok) begin
            state_next      = `MBS_ST_MUTE;
            via_bypass_next = 1'b0;
          end else if (bypass_ok) begin
            state_next = `MBS_ST_BYPASS;
          end else begin
            state_next = `MBS_ST_STOP;
          end
        end
      end
      `MBS_ST_STOP: begin
        if (bypass_ok) begin
          state_next = `MBS_ST_BYPASS;
        end else if (curtain_clear) begin
          state_next = `MBS_ST_INTERLOCK;
        end
      end
      `MBS_ST_BYPASS: begin
        if (!bypass_ok) begin
          state_next = `MBS_ST_STOP;
        end else if (start_cmd) begin
          state_next      = `MBS_ST_MUTE;
          via_bypass_next = 1'b1;
        end
      end
      `MBS_ST_MUTE: begin
        if (curtain_clear) begin
          state_next = `MBS_ST_RUN;
        end else if (!any_sensor) begin
          state_next = `MBS_ST_STOP;
        end else if (via_bypass_reg && mute_timeout) begin
          state_next = `MBS_ST_BYPASS;
        end
      end
      default: begin
        state_next = `MBS_ST_INTERLOCK;
      end
    endcase
  end

  // state registers
  // reset into interlock
  always @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      state_reg      <= `MBS_ST_INTERLOCK;
      armed_reg      <= 1'b0;
      via_bypass_reg <= 1'b0;
      boot_reg       <= 1'b1;
    end else begin
      state_reg      <= state_next;
      armed_reg      <= armed_next;
      via_bypass_reg <= via_bypass_next;
      boot_reg       <= 1'b0;
    end
  end

  // registered outputs follow the next state
  always @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      o_safety_switching_output_a <= 1'b0;
      o_safety_switching_output_b <= 1'b0;
      o_mute_lamp                 <= 1'b0;
      o_mute_aux                  <= 1'b0;
      o_diag_code                 <= `MBS_DIAG_HALT;
      o_state                     <= `MBS_ST_INTERLOCK;
    end else begin
      o_state <= state_next;
      case (state_next)
        `MBS_ST_RUN: begin
          o_safety_switching_output_a <= 1'b1;
          o_safety_switching_output_b <= 1'b1;
          o_mute_lamp                 <= 1'b0;
          o_mute_aux                  <= 1'b0;
          o_diag_code                 <= `MBS_DIAG_RUN;
        end
        `MBS_ST_MUTE: begin
          o_safety_switching_output_a <= 1'b1;
          o_safety_switching_output_b <= 1'b1;
          o_mute_lamp                 <= 1'b1;
          o_mute_aux                  <= 1'b1;
          o_diag_code                 <= `MBS_DIAG_MUTE;
        end
        `MBS_ST_BYPASS: begin
          o_safety_switching_output_a <= 1'b0;
          o_safety_switching_output_b <= 1'b0;
          o_mute_lamp                 <= blink_reg;
          o_mute_aux                  <= blink_reg;
          o_diag_code                 <= `MBS_DIAG_BYPASS;
        end
        default: begin
          o_safety_switching_output_a <= 1'b0;
          o_safety_switching_output_b <= 1'b0;
          o_mute_lamp                 <= 1'b0;
          o_mute_aux                  <= 1'b0;
          o_diag_code                 <= `MBS_DIAG_HALT;
        end
      endcase
    end
  end

endmodule // mbs_state_ctrl
`default_nettype wire

//--- verif/mbs_chk_props.sv
// checker for the muting and bypass state control
`timescale 1ns/1ps
`default_nettype none
module mbs_chk #(
  parameter integer BLINK_HALF_CYC = 10,
  parameter integer DEBOUNCE_CYC   = 4
) (
  input wire       I_CLK_SYS,
  input wire       I_SYS_RST,
  input wire [3:0] i_mute_sensor,
  input wire       i_mute_enable,
  input wire [1:0] i_bypass_cfg,
  input wire       i_start,
  input wire       o_safety_switching_output_a,
  input wire       o_safety_switching_output_b,
  input wire       o_mute_lamp,
  input wire       o_mute_aux,
  input wire [7:0] o_diag_code,
  input wire [2:0] o_state
);
  wire [2:0] s  = o_state;
  wire       oa = o_safety_switching_output_a;
  int        low_reg;
  int        mute_reg;
  logic [2:0] prev_reg;
  // start idle length and bypass mute length
  always @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      low_reg  <= 0;
      mute_reg <= 0;
      prev_reg <= 3'h0;
    end else begin
      low_reg  <= i_start ? 0 : low_reg + 1;
      mute_reg <= (s == 3'h4 && (mute_reg != 0 || prev_reg == 3'h3)) ?
                  mute_reg + 1 : 0;
      prev_reg <= s;
    end
  end
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (I_SYS_RST);
  out_state_a: assert property (s == $past(s) |->
    oa == (s == 3'h1 || s == 3'h4) && o_safety_switching_output_b == oa)
    else $error("safety outputs off state");
  bypass_ind_a: assert property (s == 3'h3 && $past(s) == 3'h3 |->
    o_diag_code == 8'h03 && !oa) else $error("bypass indication");
  mute_ind_a: assert property (s == 3'h4 && $past(s) == 3'h4 |->
    o_diag_code == 8'h02 && o_mute_lamp && o_mute_aux)
    else $error("mute indication");
  run_ind_a: assert property (s == 3'h1 && $past(s) == 3'h1 |->
    o_diag_code == 8'h00 && !o_mute_lamp) else $error("run indication");
  aux_blink_a: assert property (s == 3'h3 |-> ##[1:24]
    (s != 3'h3 || $changed(o_mute_aux))) else $error("aux not blinking");
  bypass_cond_a: assert property (s == 3'h3 && $past(s) != 3'h3 |->
    $past(i_bypass_cfg) == 2'h3 && $past(i_mute_enable))
    else $error("bypass without enable");
  start_rel_a: assert property ((s == 3'h4 && $past(s) == 3'h3) ||
    (s == 3'h1 && $past(s) == 3'h0) |-> low_reg >= DEBOUNCE_CYC)
    else $error("start taken before release");
  mute_stop_a: assert property (s == 3'h2 && $past(s) == 3'h4 |->
    $past(i_mute_sensor) == 4'h0) else $error("mute stop with sensor");
  mute_limit_a: assert property (mute_reg < 1202 * BLINK_HALF_CYC)
    else $error("bypass mute too long");
  cover property (s == 3'h3 ##1 s == 3'h4);
  cover property (s == 3'h4 ##1 s == 3'h2);
  cover property (s == 3'h4 ##1 s == 3'h3);
endmodule // mbs_chk
bind mbs_state_ctrl mbs_chk #(
  .BLINK_HALF_CYC(BLINK_HALF_CYC), .DEBOUNCE_CYC(DEBOUNCE_CYC)
) chk_u (.I_CLK_SYS(I_CLK_SYS), .I_SYS_RST(I_SYS_RST),
  .i_mute_sensor(i_mute_sensor), .i_mute_enable(i_mute_enable),
  .i_bypass_cfg(i_bypass_cfg), .i_start(i_start),
  .o_safety_switching_output_a(o_safety_switching_output_a),
  .o_safety_switching_output_b(o_safety_switching_output_b),
  .o_mute_lamp(o_mute_lamp), .o_mute_aux(o_mute_aux),
  .o_diag_code(o_diag_code), .o_state(o_state));
`default_nettype wire

//--- verif/mbs_field.sv
// field side model: curtain, muting sensors and start button
`timescale 1ns/1ps
`default_nettype none
module mbs_field (
  input  wire        i_clk,
  input  wire        i_clear,
  input  wire  [3:0] i_sns,
  input  wire        i_press,
  output logic       o_cur_a,
  output logic       o_cur_b,
  output logic [3:0] o_sns,
  output logic       o_start
);
  int n;
  // press with a one-cycle contact bounce, then release
  initial begin
    o_start = 1'h0;
    forever begin
      @(posedge i_clk iff i_press);
      for (n = 0; n < 20; n++) begin
        #1 o_start = (n != 1) && (n < 12);
        @(posedge i_clk);
      end
    end
  end
  assign o_cur_a = i_clear;
  assign o_cur_b = i_clear;
  assign o_sns   = i_sns;
endmodule // mbs_field
`default_nettype wire

//--- verif/mbs_state_ctrl_tb_top.sv
// self-checking bench for the muting and bypass state control
`timescale 1ns/1ps
`default_nettype none
module mbs_state_ctrl_tb_top;
  logic       clk, rst, clr, prs, en;
  logic [3:0] sns;
  logic [1:0] cfg;
  wire        ca, cb, strt, sa, sb, lamp, aux;
  wire  [3:0] sw;
  wire  [7:0] diag;
  wire  [2:0] state;
  int         error_cnt = 0;
  int         checked = 0;
  mbs_state_ctrl #(.BLINK_HALF_CYC(10), .DEBOUNCE_CYC(4)) dut_u (
    .I_CLK_SYS(clk), .I_SYS_RST(rst), .i_curtain_a(ca), .i_curtain_b(cb),
    .i_mute_sensor(sw), .i_mute_enable(en), .i_bypass_cfg(cfg),
    .i_start(strt), .o_safety_switching_output_a(sa),
    .o_safety_switching_output_b(sb), .o_mute_lamp(lamp), .o_mute_aux(aux),
    .o_diag_code(diag), .o_state(state));
  mbs_field fld_u (.i_clk(clk), .i_clear(clr), .i_sns(sns), .i_press(prs),
    .o_cur_a(ca), .o_cur_b(cb), .o_sns(sw), .o_start(strt));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic press;
    prs = 1'h1;
    step(1);
    prs = 1'h0;
    step(40);
  endtask
  task automatic field(input logic c, input logic [3:0] s);
    clr = c;
    sns = s;
    step(6);
  endtask
  task automatic t_example;
    logic [1:0] x;
    chk({state, sa, sb}, 5'h00);
    press;
    chk({state, sa, sb}, 5'h07);
    field(1'h0, 4'h3);
    chk({state, sa}, 4'h6);
    chk(diag, 8'h03);
    x = {lamp, aux};
    step(10);
    chk({lamp, aux}, {6'h00, ~x});
    press;
    chk({state, sa, lamp, aux}, 6'h27);
    chk(diag, 8'h02);
    field(1'h1, 4'h3);
    chk({state, lamp, sa}, 5'h05);
    chk(diag, 8'h00);
    field(1'h1, 4'h0);
    chk(state, 3'h1);
    field(1'h0, 4'h3);
    chk(state, 3'h4);
    field(1'h1, 4'h0);
    $display("example done");
  endtask
  task automatic t_refuse;
    cfg = 2'h1;
    field(1'h0, 4'h4);
    chk({state, sa}, 4'h4);
    cfg = 2'h3;
    step(6);
    chk(state, 3'h3);
    en = 1'h0;
    step(6);
    chk(state, 3'h2);
    en = 1'h1;
    step(6);
    chk(state, 3'h3);
    $display("refuse done");
  endtask
  task automatic t_mute_stop;
    press;
    chk(state, 3'h4);
    field(1'h0, 4'h0);
    chk({state, sa}, 4'h4);
    field(1'h1, 4'h0);
    $display("mute stop done");
  endtask
  task automatic t_limit;
    int i;
    press;
    field(1'h0, 4'h4);
    press;
    step(11900);
    chk(state, 3'h4);
    // limit ends at most 1200 half periods after entry, so 80 cycles here
    for (i = 0; i < 80 && state !== 3'h3; i++) step(1);
    chk(state, 3'h3);
    $display("limit done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // clock
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  // watchdog
  initial begin
    #4000000;
    error_cnt++;
    tally_and_finish;
  end
  // main sequence
  initial begin
    rst = 1'h1;
    clr = 1'h1;
    prs = 1'h0;
    en  = 1'h1;
    cfg = 2'h3;
    sns = 4'h4;
    repeat (3) @(posedge clk);
    #1 rst = 1'h0;
    step(2);
    t_example;
    t_refuse;
    t_mute_stop;
    t_limit;
    tally_and_finish;
  end
endmodule // mbs_state_ctrl_tb_top
`default_nettype wire
